// ==== rtl/phy_status_defines.vh ====
// Purpose: constants for the strap, skew and pattern-checker status bank
// Assumes: 32-bit AXI4-Lite data, 16-bit registers in the low half
// Notes: printed offsets are indices; byte address is four times the index
`ifndef PHY_STATUS_DEFINES_VH
`define PHY_STATUS_DEFINES_VH

`define IDX_SKEW_STATUS 8'h55
`define IDX_STRAP_ONE 8'h6E
`define IDX_STRAP_TWO 8'h6F
`define IDX_BYTE_TOTAL 8'h71
`define IDX_ERR_CTRL 8'h72
`define IDX_COUNT_MODE 8'h16
`define IDX_CHECKER_IN 8'hF0

`define ADDR_W 10
`define BYTE_TOTAL_MAX 16'hFFFF
`define ERR_COUNT_MAX 8'hFF
`define BIT_LOCK 0
`define BIT_LOCK_CLEAR 1
`define BIT_PKT_OVF 10
`define BIT_BYTE_OVF 9
`define COUNT_MODE_RESET 1'b0
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

// ==== rtl/phy_strap_skew_prbs_status.v ====
// Purpose: status bank for skew, latched straps and checker counts, with a writable count mode and control word
// Assumes: strap pins steady around reset; checker events come on sys_clk_i
// Notes: registers reached over AXI4-Lite; unmapped reads return SLVERR
//   strap values are captured once, at the third enabled edge after reset
//   the control word bits are write strobes and read back as error-count bits 1:0
//
// Summary of operation
// R1: bits 7:4 of skew status show channel B alignment cycles.
// R2: bits 3:0 of skew status show channel A alignment cycles.
// R3: strap word one bits 15,14,13: mirror on, downshift on, clock out off.
// R4: strap word one bits 12,11,10: parallel if off, serial on, auto-x off.
// R5: bit 9 forced crossover, bit 8 half duplex, bit 7 negotiation off.
// R6: bit 5 negotiation select, bits 3:0 mgmt address; bits 6,4 zero.
// R7: strap word two bit 10 shows quick link drop strap.
// R8: strap word two bits 6:4 show transmit clock delay low bits.
// R9: strap word two bits 2:0 show receive clock delay low bits.
// R10: 16-bit checker byte total, reset to zero.
// R11: with mode zero the byte total saturates at FFFF.
// R12: 8-bit error-byte count in bits 7:0, reset to zero.
// R13: with mode zero the error count saturates at FF.
// R14: writing bit 0 of the control word freezes presented counter values.
// R15: writing bit 1 freezes and clears all checker counters.
// R16: bit 10 sticks on packet counter overflow until cleared by bit 1.
// R17: bit 9 sticks on byte counter overflow until cleared by bit 1.
// R18: with mode nonzero counters wrap; only the byte counter raises its overflow flag.
//
// The implementer's own choice: the AXI4-Lite register port.
`timescale 1ns/1ps
`include "phy_status_defines.vh"

module phy_strap_skew_prbs_status
(
  input wire sys_clk_i,
  input wire reset_i,
  input wire clk_en_i,
  input wire [3:0] pair_a_align_cycles_i,
  input wire [3:0] pair_b_align_cycles_i,
  input wire strap_mirror_i,
  input wire strap_downshift_i,
  input wire latched_refout_off_i,
  input wire latched_parallel_if_off_i,
  input wire strap_serial_if_i,
  input wire latched_auto_crossover_off_i,
  input wire latched_forced_crossover_i,
  input wire latched_half_duplex_i,
  input wire latched_negotiation_off_i,
  input wire latched_negotiation_select_i,
  input wire [3:0] latched_mgmt_address_i,
  input wire latched_quick_drop_i,
  input wire [2:0] strap_tx_delay_i,
  input wire [2:0] strap_rx_delay_i,
  input wire checker_byte_i,
  input wire checker_bad_byte_i,
  input wire checker_packet_wrap_i,
  input wire [`ADDR_W-1:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output reg s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output reg s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  input wire [`ADDR_W-1:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output reg s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready
);

  // ************************************************************
  // decoding
  // ************************************************************
  function [7:0] word_index;
    input [`ADDR_W-1:0] addr;
    begin
      word_index = addr[`ADDR_W-1:2];
    end
  endfunction

  // ************************************************************
  // pin synchronisers and strap capture
  // ************************************************************
  localparam SYNC_W = 32;
  localparam STRAP_W = 21;
  wire [SYNC_W-1:0] pin_raw;
  reg [SYNC_W-1:0] pin_meta_r;
  reg [SYNC_W-1:0] pin_sync_r;
  assign pin_raw = {pair_b_align_cycles_i, pair_a_align_cycles_i,
    strap_mirror_i, strap_downshift_i, latched_refout_off_i,
    latched_parallel_if_off_i, strap_serial_if_i,
    latched_auto_crossover_off_i, latched_forced_crossover_i,
    latched_half_duplex_i, latched_negotiation_off_i,
    latched_negotiation_select_i, latched_mgmt_address_i,
    latched_quick_drop_i, strap_tx_delay_i, strap_rx_delay_i,
    checker_byte_i, checker_bad_byte_i, checker_packet_wrap_i};

  always @(posedge sys_clk_i)
  begin
    if (clk_en_i)
    begin
      pin_meta_r <= pin_raw;
      pin_sync_r <= pin_meta_r;
    end
  end

  wire [7:0] skew_now = pin_sync_r[31:24];
  wire [STRAP_W-1:0] strap_now = pin_sync_r[23:3];
  wire byte_ev = pin_sync_r[2];
  wire bad_ev = pin_sync_r[1];
  wire pkt_wrap_ev = pin_sync_r[0];

  // straps caught at the third enabled edge after reset release, once the sync is full
  reg [STRAP_W-1:0] strap_r;
  reg [1:0] strap_wait_r;
  always @(posedge sys_clk_i)
  begin
    if (reset_i)
      strap_wait_r <= 2'h0;
    else if (clk_en_i && strap_wait_r != 2'h3)
      strap_wait_r <= strap_wait_r + 2'h1;
  end
  always @(posedge sys_clk_i)
  begin
    if (reset_i)
      strap_r <= 21'h000000;
    else if (clk_en_i && strap_wait_r == 2'h2)
      strap_r <= strap_now;
  end

  // ************************************************************
  // latched strap fields
  // ************************************************************
  wire mirror_on = strap_r[20];
  wire downshift_on = strap_r[19];
  wire refout_off = strap_r[18];
  wire parallel_off = strap_r[17];
  wire serial_on = strap_r[16];
  wire auto_x_off = strap_r[15];
  wire forced_x = strap_r[14];
  wire half_duplex = strap_r[13];
  wire neg_off = strap_r[12];
  wire neg_select = strap_r[11];
  wire [3:0] mgmt_addr = strap_r[10:7];
  wire quick_drop = strap_r[6];
  wire [2:0] tx_delay = strap_r[5:3];
  wire [2:0] rx_delay = strap_r[2:0];

  wire [15:0] strap_word_one = {mirror_on, downshift_on, refout_off,
    parallel_off, serial_on, auto_x_off, forced_x, half_duplex,
    neg_off, 1'b0, neg_select, 1'b0, mgmt_addr}; // R3 R4 R5 R6
  wire [15:0] strap_word_two = {5'h00, quick_drop, 3'h0, tx_delay,
    1'b0, rx_delay}; // R7 R8 R9

  // skew levels are live; they are not captured at reset
  reg [7:0] skew_r;
  wire [3:0] pair_b_skew = skew_r[7:4]; // R1
  wire [3:0] pair_a_skew = skew_r[3:0]; // R2
  always @(posedge sys_clk_i)
  begin
    if (reset_i)
      skew_r <= 8'h00;
    else if (clk_en_i)
      skew_r <= skew_now;
  end

  // ************************************************************
  // checker counters
  // ************************************************************
  reg mode_r;
  reg [15:0] bytes_live_r;
  reg [7:0] bad_live_r;
  reg [15:0] checker_bytes_seen_r;
  reg [7:0] checker_bad_bytes_r;
  reg frozen_r;
  reg checker_packets_overflowed_r;
  reg checker_bytes_overflowed_r;
  reg lock_wr;
  reg clear_wr;

  wire byte_at_max = bytes_live_r == `BYTE_TOTAL_MAX;
  wire bad_at_max = bad_live_r == `ERR_COUNT_MAX;

  // count enables: mode zero pins each counter at its top value
  wire byte_step = byte_ev && !(byte_at_max && !mode_r);
  wire bad_step = bad_ev && !(bad_at_max && !mode_r);
  wire byte_wraps = byte_ev && byte_at_max && mode_r;

  always @(posedge sys_clk_i)
  begin
    if (reset_i)
    begin
      bytes_live_r <= 16'h0000; // R10
      bad_live_r <= 8'h00; // R12
      checker_bytes_seen_r <= 16'h0000;
      checker_bad_bytes_r <= 8'h00;
      frozen_r <= 1'b0;
      checker_packets_overflowed_r <= 1'b0;
      checker_bytes_overflowed_r <= 1'b0;
    end
    else if (clk_en_i)
    begin
      if (clear_wr)
      begin
        bytes_live_r <= 16'h0000; // R15
        bad_live_r <= 8'h00;
        checker_bytes_seen_r <= 16'h0000;
        checker_bad_bytes_r <= 8'h00;
        frozen_r <= 1'b1;
      end
      else
      begin
        if (byte_step) // R11
          bytes_live_r <= bytes_live_r + 16'h0001; // R18
        if (bad_step) // R13
          bad_live_r <= bad_live_r + 8'h01; // R18
        if (lock_wr)
        begin
          frozen_r <= 1'b1; // R14
          checker_bytes_seen_r <= bytes_live_r;
          checker_bad_bytes_r <= bad_live_r;
        end
        else if (!frozen_r)
        begin
          checker_bytes_seen_r <= bytes_live_r;
          checker_bad_bytes_r <= bad_live_r;
        end
      end
      // a new overflow in the clearing cycle still sets the flag
      if (pkt_wrap_ev)
        checker_packets_overflowed_r <= 1'b1; // R16
      else if (clear_wr)
        checker_packets_overflowed_r <= 1'b0; // R16
      if (byte_wraps)
        checker_bytes_overflowed_r <= 1'b1; // R17
      else if (clear_wr)
        checker_bytes_overflowed_r <= 1'b0; // R17
    end
  end

  // ************************************************************
  // axi4-lite write channel
  // ************************************************************
  reg aw_held_r;
  reg w_held_r;
  reg [7:0] aw_idx_r;
  reg [31:0] wdata_r;
  reg [3:0] wstrb_r;
  wire do_write = aw_held_r && w_held_r && !s_axi_bvalid;

  always @*
  begin
    lock_wr = 1'b0;
    clear_wr = 1'b0;
    if (do_write && aw_idx_r == `IDX_ERR_CTRL && wstrb_r[0])
    begin
      lock_wr = wdata_r[`BIT_LOCK]; // R14
      clear_wr = wdata_r[`BIT_LOCK_CLEAR]; // R15
    end
  end

  always @(posedge sys_clk_i)
  begin
    if (reset_i)
    begin
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `RESP_OKAY;
      aw_held_r <= 1'b0;
      w_held_r <= 1'b0;
      aw_idx_r <= 8'h00;
      wdata_r <= 32'h00000000;
      wstrb_r <= 4'h0;
      mode_r <= `COUNT_MODE_RESET;
    end
    else if (clk_en_i)
    begin
      s_axi_awready <= !aw_held_r && !s_axi_awready;
      s_axi_wready <= !w_held_r && !s_axi_wready;
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_held_r <= 1'b1;
        aw_idx_r <= word_index(s_axi_awaddr);
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_held_r <= 1'b1;
        wdata_r <= s_axi_wdata;
        wstrb_r <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end
      if (do_write)
      begin
        aw_held_r <= 1'b0;
        w_held_r <= 1'b0;
        s_axi_bvalid <= 1'b1;
        case (aw_idx_r)
          `IDX_ERR_CTRL, `IDX_SKEW_STATUS, `IDX_STRAP_ONE,
          `IDX_STRAP_TWO, `IDX_BYTE_TOTAL:
            s_axi_bresp <= `RESP_OKAY;
          `IDX_COUNT_MODE:
          begin
            s_axi_bresp <= `RESP_OKAY;
            if (wstrb_r[0])
              mode_r <= wdata_r[0];
          end
          default:
            s_axi_bresp <= `RESP_SLVERR;
        endcase
      end
      else if (s_axi_bvalid && s_axi_bready)
        s_axi_bvalid <= 1'b0;
    end
  end

  // ************************************************************
  // axi4-lite read channel
  // ************************************************************
  reg [31:0] rd_word;
  reg rd_hit;
  always @*
  begin
    rd_word = 32'h00000000;
    rd_hit = 1'b1;
    case (word_index(s_axi_araddr))
      `IDX_SKEW_STATUS:
        rd_word[7:0] = {pair_b_skew, pair_a_skew}; // R1 R2
      `IDX_STRAP_ONE:
        rd_word[15:0] = strap_word_one; // R3 R4 R5 R6
      `IDX_STRAP_TWO:
        rd_word[15:0] = strap_word_two; // R7 R8 R9
      `IDX_BYTE_TOTAL:
        rd_word[15:0] = checker_bytes_seen_r; // R10
      `IDX_ERR_CTRL:
        rd_word[15:0] = {5'h00, checker_packets_overflowed_r,
          checker_bytes_overflowed_r, 1'b0,
          checker_bad_bytes_r}; // R12 R16 R17
      `IDX_COUNT_MODE:
        rd_word[0] = mode_r;
      default:
        rd_hit = 1'b0;
    endcase
  end

  always @(posedge sys_clk_i)
  begin
    if (reset_i)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= `RESP_OKAY;
    end
    else if (clk_en_i)
    begin
      if (s_axi_arvalid && s_axi_arready)
      begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= rd_word;
        s_axi_rresp <= rd_hit ? `RESP_OKAY : `RESP_SLVERR;
      end
      else
      begin
        if (s_axi_rvalid && s_axi_rready)
          s_axi_rvalid <= 1'b0;
        s_axi_arready <= !s_axi_rvalid && !s_axi_arready;
      end
    end
  end

endmodule // phy_strap_skew_prbs_status

// ==== verification/phy_status_chk_asserts.sv ====
// Purpose: protocol and readback checks on the status bank ports
// Assumes: clk_en_i high whenever a check is meant to count
// Notes: bound to the design top by name
`timescale 1ns/1ps
module phy_status_chk
(
  input wire sys_clk_i,
  input wire reset_i,
  input wire clk_en_i,
  input wire s_axi_awvalid,
  input wire s_axi_awready,
  input wire s_axi_wvalid,
  input wire s_axi_wready,
  input wire s_axi_bvalid,
  input wire s_axi_bready,
  input wire [1:0] s_axi_bresp,
  input wire s_axi_arvalid,
  input wire s_axi_arready,
  input wire s_axi_rvalid,
  input wire s_axi_rready,
  input wire [1:0] s_axi_rresp,
  input wire [31:0] s_axi_rdata
);
  // ****
  // checks
  // ****
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (reset_i || !clk_en_i);
  a_bresp_held: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid && $stable(s_axi_bresp)) else $error("bresp dropped");
  a_rdata_held: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata)) else $error("rdata dropped");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=>
    s_axi_rvalid) else $error("read not answered");
  a_ar_drops: assert property (s_axi_arvalid && s_axi_arready |=>
    !s_axi_arready) else $error("arready stayed high");
  a_write_answer: assert property (s_axi_awvalid && s_axi_awready
    && s_axi_wvalid && s_axi_wready |-> ##[1:2] s_axi_bvalid)
    else $error("write not answered");
  a_upper_zero: assert property (s_axi_rvalid |->
    s_axi_rdata[31:16] == 16'h0000) else $error("upper half set");
  a_error_zero: assert property (s_axi_rvalid && s_axi_rresp == 2'h2
    |-> s_axi_rdata == 32'h0) else $error("error read not zero");
  a_reset_idle: assert property ($fell(reset_i) |->
    !s_axi_bvalid && !s_axi_rvalid) else $error("busy after reset");
endmodule // phy_status_chk

bind phy_strap_skew_prbs_status phy_status_chk i_chk (.*);

// ==== verification/phy_strap_skew_prbs_status_tb.sv ====
// Purpose: directed checks of the status bank over AXI4-Lite
// Assumes: a checker input held high counts one event per cycle
// Notes: straps are taken again at each reset
`timescale 1ns/1ps
module phy_strap_skew_prbs_status_tb;
  reg sys_clk_i = 0, reset_i = 1, clk_en_i = 1;
  reg [3:0] pair_a_align_cycles_i = 4'h9, pair_b_align_cycles_i = 4'h6;
  reg checker_byte_i = 0, checker_bad_byte_i = 0, checker_packet_wrap_i = 0;
  reg [15:0] s1 = 16'hAAAA;
  reg [10:0] s2 = 11'h453;
  reg [9:0] s_axi_awaddr = 0, s_axi_araddr = 0;
  reg [31:0] s_axi_wdata = 0;
  reg [3:0] s_axi_wstrb = 4'hF;
  reg s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
  reg s_axi_arvalid = 0, s_axi_rready = 0;
  wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  wire s_axi_rvalid;
  wire [1:0] s_axi_bresp, s_axi_rresp;
  wire [31:0] s_axi_rdata;
  reg [1:0] rsp;
  integer error_cnt = 0, tests_run = 0;
  // ****
  // design and clock
  // ****
  phy_strap_skew_prbs_status i_dut (.*,
    .strap_mirror_i(s1[15]), .strap_downshift_i(s1[14]),
    .latched_refout_off_i(s1[13]), .latched_parallel_if_off_i(s1[12]),
    .strap_serial_if_i(s1[11]), .latched_auto_crossover_off_i(s1[10]),
    .latched_forced_crossover_i(s1[9]), .latched_half_duplex_i(s1[8]),
    .latched_negotiation_off_i(s1[7]),
    .latched_negotiation_select_i(s1[5]),
    .latched_mgmt_address_i(s1[3:0]), .latched_quick_drop_i(s2[10]),
    .strap_tx_delay_i(s2[6:4]), .strap_rx_delay_i(s2[2:0]));
  initial forever #5 sys_clk_i = ~sys_clk_i;
  task report_and_stop;
    begin
      $display("mismatches %0d of %0d checks", error_cnt, tests_run);
      if (error_cnt == 0 && tests_run > 0)
        $display("== PASSED ==");
      else
        $display("== FAILED ==");
      $finish;
    end
  endtask
  task chk(input [31:0] s, input [31:0] e);
    begin
      tests_run = tests_run + 1;
      if (s !== e)
      begin
        error_cnt = error_cnt + 1;
        $display("[FAIL] %0t seen %h exp %h", $time, s, e);
      end
    end
  endtask
  task clk(input integer n);
    repeat (n) @(posedge sys_clk_i);
  endtask
  // a wait that runs out ends the run
  task hang(input integer n);
    if (n > 99)
    begin
      error_cnt = error_cnt + 1;
      report_and_stop;
    end
  endtask
  task wr(input [9:0] a, input [31:0] d);
    integer n;
    begin
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1;
      s_axi_wvalid <= 1;
      s_axi_bready <= 1;
      n = 0;
      do
      begin
        @(posedge sys_clk_i);
        if (s_axi_awready) s_axi_awvalid <= 0;
        if (s_axi_wready) s_axi_wvalid <= 0;
        n = n + 1;
        hang(n);
      end
      while (s_axi_bvalid !== 1'b1);
      rsp = s_axi_bresp;
      s_axi_bready <= 0;
      clk(1);
    end
  endtask
  task rd(input [9:0] a, input [31:0] e);
    integer n;
    begin
      s_axi_araddr <= a;
      s_axi_arvalid <= 1;
      s_axi_rready <= 1;
      n = 0;
      do
      begin
        @(posedge sys_clk_i);
        if (s_axi_arready) s_axi_arvalid <= 0;
        n = n + 1;
        hang(n);
      end
      while (s_axi_rvalid !== 1'b1);
      s_axi_rready <= 0;
      rsp = s_axi_rresp;
      chk(s_axi_rdata, e);
      clk(1);
    end
  endtask
  task feed(input b, input e, input integer n);
    begin
      checker_byte_i <= b;
      checker_bad_byte_i <= e;
      clk(n);
      checker_byte_i <= 0;
      checker_bad_byte_i <= 0;
      clk(6);
    end
  endtask
  task rst;
    begin
      reset_i <= 1;
      clk(8);
      reset_i <= 0;
      clk(6);
    end
  endtask
  // ****
  // scenarios
  // ****
  task t_straps;
    begin
      rd(10'h154, 32'h69);
      wr(10'h154, 32'hFFFF);
      chk(rsp, 32'h0);
      rd(10'h154, 32'h69);
      wr(10'h3FC, 32'h0);
      chk(rsp, 32'h2);
      rd(10'h1B8, 32'hAAAA);
      rd(10'h1BC, 32'h453);
      rd(10'h1C4, 32'h0);
      rd(10'h1C8, 32'h0);
      rd(10'h3FC, 32'h0);
      chk(rsp, 32'h2);
      s1 <= 16'h5555;
      s2 <= 11'h024;
      rst;
      rd(10'h1B8, 32'h5505);
      rd(10'h1BC, 32'h24);
    end
  endtask
  task t_count;
    begin
      feed(1, 1, 300);
      rd(10'h1C4, 32'h12C);
      rd(10'h1C8, 32'hFF);
      clk_en_i <= 0;
      feed(1, 0, 5);
      clk_en_i <= 1;
      rd(10'h1C4, 32'h12C);
      wr(10'h1C8, 32'h1);
      feed(1, 0, 5);
      rd(10'h1C4, 32'h12C);
      wr(10'h1C8, 32'h2);
      rd(10'h1C4, 32'h0);
      rd(10'h1C8, 32'h0);
    end
  endtask
  task t_pkt;
    begin
      rst;
      checker_packet_wrap_i <= 1;
      clk(1);
      checker_packet_wrap_i <= 0;
      clk(8);
      rd(10'h1C8, 32'h400);
      wr(10'h1C8, 32'h2);
      rd(10'h1C8, 32'h0);
    end
  endtask
  task t_wrap;
    begin
      rst;
      feed(1, 1, 65537);
      rd(10'h1C4, 32'hFFFF);
      rd(10'h1C8, 32'hFF);
      wr(10'h58, 32'h1);
      rd(10'h58, 32'h1);
      feed(1, 1, 2);
      rd(10'h1C4, 32'h1);
      rd(10'h1C8, 32'h201);
    end
  endtask
  initial
  begin
    rst;
    t_straps;
    t_count;
    t_pkt;
    t_wrap;
    report_and_stop;
  end
endmodule // phy_strap_skew_prbs_status_tb
